// ---- amsc_pkg.sv ----
// constants, field layouts and state carriers for the accelerometer mode and
// sample control block; assumes a 50 MHz system clock and an apb3 master.
// Notes on behaviour
// - pin b doubles as external sample trigger
// - pin a doubles as external clock input
// - standby, measurement and wake-up modes exist
// - measurement samples continuously at selected rate
// - wake-up samples about six times per second
// - wake-up motion: switch mode, interrupt, wake output
// - wake-up uses one-sample activity, registers stay live
// - standby stops all sampling
// - standby keeps pending flags, raises none new
// - reset leaves device in standby
// - samples are 12-bit, scale follows range
// - out-of-range samples clip at full scale
// - output rates span 12.5 Hz to 400 Hz
// - filter pole at quarter or half rate
// - filter pole defaults to quarter rate
package amsc_pkg;

	// timing
	localparam int unsigned SYS_CLK_HZ    = 50_000_000;
	localparam int unsigned ODR_MAX_HZ    = 400;
	localparam int unsigned WAKE_RATE_HZ  = 6;
	localparam int unsigned ODR_MAX_DIV   = SYS_CLK_HZ / ODR_MAX_HZ;
	localparam int unsigned WAKE_DIV      = SYS_CLK_HZ / WAKE_RATE_HZ;
	localparam int unsigned EXT_ODR_DIV   = 64;
	localparam int unsigned EXT_WAKE_DIV  = 4096;
	localparam logic [2:0]  ODR_SEL_MAX   = 3'h5; // code 5 is 400 Hz, code 0 is 12.5 Hz
	localparam logic [2:0]  ODR_SEL_RST   = 3'h3;

	// apb register map
	localparam int unsigned ADDR_W        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_ACT       = 8'h04;
	localparam logic [7:0]  OFS_STATUS    = 8'h08;
	localparam logic [7:0]  OFS_INT_CLR   = 8'h0C;
	localparam logic [7:0]  OFS_INT_EN    = 8'h10;
	localparam logic [7:0]  OFS_SMP_XY    = 8'h14;
	localparam logic [7:0]  OFS_SMP_Z     = 8'h18;

	// field positions
	localparam int unsigned CTRL_W        = 12;
	localparam int unsigned ACT_THR_LSB   = 0;
	localparam int unsigned ACT_TIME_LSB  = 16;
	localparam int unsigned STAT_DRDY     = 0;
	localparam int unsigned STAT_ACT      = 1;
	localparam int unsigned STAT_W        = 2;
	localparam int unsigned STAT_MODE_LSB = 4;
	localparam int unsigned STAT_AWAKE    = 6;
	localparam int unsigned SMP_Y_LSB     = 16;

	// sample path
	localparam int unsigned RAW_W         = 16;
	localparam int unsigned SMP_W         = 12;
	localparam logic [15:0] CLIP_CODE     = 16'h0FFF;
	localparam logic [11:0] ACT_THR_RST   = 12'h0_100;
	localparam logic [7:0]  ACT_TIME_RST  = 8'h01;

	typedef enum logic [1:0] {
		AMSC_MODE_STBY = 2'b00,
		AMSC_MODE_MEAS = 2'b10,
		AMSC_MODE_WAKE = 2'b11
	} amsc_mode_t;

	// control word, packed low field last: req_mode at [1:0]
	typedef struct packed {
		logic       awake_en;    // [11]
		logic       auto_meas;   // [10]
		logic       ext_trig_en; // [9]
		logic       ext_clk_en;  // [8]
		logic       filter_pole_half_select; // [7]
		logic [2:0] odr;         // [6:4]
		logic [1:0] range;       // [3:2]
		logic [1:0] req_mode;    // [1:0]
	} amsc_ctrl_t;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} amsc_raw_t;

	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
	} amsc_smp_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} amsc_div_st_t;

	typedef struct packed {
		amsc_ctrl_t  ctrl;
		amsc_mode_t  mode;
		logic [11:0] thresh;
		logic [7:0]  act_time;
		logic [7:0]  act_cnt;
		logic [1:0]  status;
		logic [1:0]  int_en;
		amsc_smp_t   smp;
		logic        smp_valid;
		logic        awake;
		logic        irq;
		logic        pin_a_oe;
		logic        pin_b_oe;
		logic [1:0]  sync_a;
		logic [1:0]  sync_b;
		logic        prev_a;
		logic        prev_b;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} amsc_st_t;

endpackage

// ---- amsc_tick_div.sv ----
// programmable tick divider: counts step pulses and fires once per limit+1.
// assumes step and limit come from logic on the same system clock.
`timescale 1ns/1ps
module amsc_tick_div
	import amsc_pkg::*;
(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	// rate control
	input  wire logic        i_step,
	input  wire logic [31:0] i_limit,
	// tick out
	output logic             o_tick
);

	amsc_div_st_t st_q;
	amsc_div_st_t st_d;

	// count steps; a shrinking limit restarts at once instead of wrapping 2^32
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (i_step) begin
			if (st_q.cnt >= i_limit) begin
				st_d.cnt  = 32'h0000_0000;
				st_d.tick = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 32'h0000_0001;
			end
		end
	end

	// state register
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_tick = st_q.tick;

endmodule

// ---- amsc_top.sv ----
// accelerometer mode and sample control with apb register access.
// assumes raw axis words arrive on the system clock; the two irq pins are
// asynchronous and are synchronised here before use.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module amsc_top
	import amsc_pkg::*;
#(
	parameter logic [31:0] ODR_MAX_DIV_P  = ODR_MAX_DIV,
	parameter logic [31:0] WAKE_DIV_P     = WAKE_DIV,
	parameter logic [31:0] EXT_ODR_DIV_P  = EXT_ODR_DIV,
	parameter logic [31:0] EXT_WAKE_DIV_P = EXT_WAKE_DIV
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	// apb slave
	input  wire logic [7:0]  i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// raw acceleration from the front end
	input  wire amsc_raw_t   i_raw,
	// dual-use pins
	input  wire logic        i_irq_out_a_extclk_in,
	output logic             o_irq_out_a_extclk_out,
	output logic             o_irq_out_a_extclk_oe,
	input  wire logic        i_irq_out_b_trigger_in,
	output logic             o_irq_out_b_trigger_out,
	output logic             o_irq_out_b_trigger_oe,
	// sample stream and status
	output amsc_smp_t        o_sample,
	output logic             o_sample_valid,
	output logic             o_irq,
	output logic             o_awake,
	output amsc_mode_t       o_mode,
	output logic [1:0]       o_range,
	output logic [2:0]       o_odr_sel,
	output logic             o_filter_pole_half_select
);

	amsc_st_t    st_q;
	amsc_st_t    st_d;
	logic        edge_a;
	logic        edge_b;
	logic        step;
	logic        odr_tick;
	logic        wake_tick;
	logic [2:0]  odr_code;
	logic [4:0]  odr_shift;
	logic [31:0] odr_limit;
	logic [31:0] wake_limit;
	logic [1:0]  rng_shift;
	amsc_raw_t   scaled;
	amsc_smp_t   clipped;
	logic        over;
	logic        cap_evt;
	logic        act_evt;
	logic [7:0]  act_need;
	logic [7:0]  act_cnt_inc;
	logic        apb_setup;
	logic        apb_wr;

	// pin edges read only the second sync stage
	assign edge_a = st_q.sync_a[1] & ~st_q.prev_a;
	assign edge_b = st_q.sync_b[1] & ~st_q.prev_b;

	// base step: system clock or edges of the external clock on pin a
	assign step = st_q.ctrl.ext_clk_en ? edge_a : 1'b1;

	// rate select; codes above the top rate fall back to 400 Hz
	assign odr_code   = (st_q.ctrl.odr > ODR_SEL_MAX) ? ODR_SEL_MAX : st_q.ctrl.odr;
	assign odr_shift  = {2'b00, ODR_SEL_MAX - odr_code};
	assign odr_limit  = ((st_q.ctrl.ext_clk_en ? EXT_ODR_DIV_P : ODR_MAX_DIV_P) << odr_shift)
		- 32'h0000_0001;
	assign wake_limit = (st_q.ctrl.ext_clk_en ? EXT_WAKE_DIV_P : WAKE_DIV_P)
		- 32'h0000_0001;

	// dividers run in every mode so mode changes find a boundary whenever steps arrive
	amsc_tick_div u_odr_div (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_step    (step),
		.i_limit   (odr_limit),
		.o_tick    (odr_tick)
	);

	amsc_tick_div u_wake_div (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_step    (step),
		.i_limit   (wake_limit),
		.o_tick    (wake_tick)
	);

	// range scaling: wider range keeps 12 bits, so each code weighs more
	assign rng_shift = (st_q.ctrl.range == 2'b11) ? 2'b10 : st_q.ctrl.range;

	// per-axis scale and clip; never wraps past full scale
	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			assign scaled[ax*RAW_W +: RAW_W] = i_raw[ax*RAW_W +: RAW_W] >> rng_shift;
			assign clipped[ax*SMP_W +: SMP_W] =
				(scaled[ax*RAW_W +: RAW_W] > CLIP_CODE) ? CLIP_CODE[11:0]
				: scaled[ax*RAW_W +: SMP_W];
		end
	endgenerate

	// motion is any axis above the activity threshold
	assign over = (clipped.x > st_q.thresh) | (clipped.y > st_q.thresh)
		| (clipped.z > st_q.thresh);

	// sample moments per mode; standby takes none
	always_comb begin
		case (st_q.mode)
			AMSC_MODE_MEAS: cap_evt = st_q.ctrl.ext_trig_en ? edge_b : odr_tick;
			AMSC_MODE_WAKE: cap_evt = wake_tick;
			AMSC_MODE_STBY: cap_evt = 1'b0;
			default:        cap_evt = 1'b0;
		endcase
	end

	// activity timer only in measurement; wake-up decides on one sample
	assign act_need    = (st_q.act_time == 8'h00) ? 8'h01 : st_q.act_time;
	assign act_cnt_inc = (st_q.act_cnt == 8'hFF) ? 8'hFF : st_q.act_cnt + 8'h01;
	assign act_evt     = cap_evt & over &
		((st_q.mode == AMSC_MODE_WAKE) | (act_cnt_inc >= act_need));

	// apb phases: answer is prepared in setup, taken in the first access cycle
	assign apb_setup = i_psel & ~i_penable;
	assign apb_wr    = i_psel & i_penable & st_q.pready & i_pwrite & ~st_q.pslverr;

	// next-state logic for the whole block
	always_comb begin
		st_d           = st_q;
		st_d.smp_valid = 1'b0;

		// pin synchronisers
		st_d.sync_a = {st_q.sync_a[0], i_irq_out_a_extclk_in};
		st_d.sync_b = {st_q.sync_b[0], i_irq_out_b_trigger_in};
		st_d.prev_a = st_q.sync_a[1];
		st_d.prev_b = st_q.sync_b[1];

		// apb read answer and error for unmapped offsets
		st_d.pready  = apb_setup;
		st_d.pslverr = 1'b0;
		st_d.prdata  = 32'h0000_0000;
		if (apb_setup) begin
			case (i_paddr)
				OFS_CTRL:    st_d.prdata[CTRL_W-1:0] = st_q.ctrl;
				OFS_ACT: begin
					st_d.prdata[ACT_THR_LSB +: 12] = st_q.thresh;
					st_d.prdata[ACT_TIME_LSB +: 8] = st_q.act_time;
				end
				OFS_STATUS: begin
					st_d.prdata[STAT_W-1:0]          = st_q.status;
					st_d.prdata[STAT_MODE_LSB +: 2]  = st_q.mode;
					st_d.prdata[STAT_AWAKE]          = st_q.awake;
				end
				OFS_INT_CLR: st_d.prdata = 32'h0000_0000;
				OFS_INT_EN:  st_d.prdata[STAT_W-1:0] = st_q.int_en;
				OFS_SMP_XY: begin
					st_d.prdata[SMP_W-1:0]          = st_q.smp.x;
					st_d.prdata[SMP_Y_LSB +: SMP_W] = st_q.smp.y;
				end
				OFS_SMP_Z:   st_d.prdata[SMP_W-1:0] = st_q.smp.z;
				default:     st_d.pslverr = 1'b1;
			endcase
		end

		// register writes; every writable register stays writable in every mode
		if (apb_wr) begin
			case (i_paddr)
				OFS_CTRL:    st_d.ctrl = amsc_ctrl_t'(i_pwdata[CTRL_W-1:0]);
				OFS_ACT: begin
					st_d.thresh   = i_pwdata[ACT_THR_LSB +: 12];
					st_d.act_time = i_pwdata[ACT_TIME_LSB +: 8];
				end
				OFS_INT_CLR: begin
					st_d.status = st_q.status & ~i_pwdata[STAT_W-1:0];
					if (i_pwdata[STAT_ACT])
						st_d.awake = 1'b0;
				end
				OFS_INT_EN:  st_d.int_en = i_pwdata[STAT_W-1:0];
				default:     st_d.status = st_q.status;
			endcase
		end

		// mode takes the requested value only at a sample boundary
		if (odr_tick) begin
			case (st_q.ctrl.req_mode)
				AMSC_MODE_MEAS: st_d.mode = AMSC_MODE_MEAS;
				AMSC_MODE_WAKE: st_d.mode = AMSC_MODE_WAKE;
				default:        st_d.mode = AMSC_MODE_STBY;
			endcase
		end

		// capture; new flags only from captures, so standby raises none
		if (cap_evt) begin
			st_d.smp       = clipped;
			st_d.smp_valid = 1'b1;
			st_d.status[STAT_DRDY] = 1'b1;
			st_d.act_cnt   = over ? act_cnt_inc : 8'h00;
		end

		// motion response; set wins over a clear in the same cycle
		if (act_evt) begin
			st_d.act_cnt          = 8'h00;
			st_d.status[STAT_ACT] = 1'b1;
			if (st_q.ctrl.awake_en)
				st_d.awake = 1'b1;
			if (st_q.mode == AMSC_MODE_WAKE && st_q.ctrl.auto_meas) begin
				st_d.mode          = AMSC_MODE_MEAS;
				st_d.ctrl.req_mode = AMSC_MODE_MEAS;
			end
		end

		// interrupt level and pin directions
		st_d.irq      = |(st_d.status & st_d.int_en);
		st_d.pin_a_oe = ~st_d.ctrl.ext_clk_en;
		st_d.pin_b_oe = ~st_d.ctrl.ext_trig_en;
	end

	// state register; reset lands in standby with quarter-rate filter pole
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q               <= '0;
			st_q.ctrl.odr      <= ODR_SEL_RST;
			st_q.mode          <= AMSC_MODE_STBY;
			st_q.thresh        <= ACT_THR_RST;
			st_q.act_time      <= ACT_TIME_RST;
			st_q.pin_a_oe      <= 1'b1;
			st_q.pin_b_oe      <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from state; pole setting drives the filter directly
	assign o_prdata                  = st_q.prdata;
	assign o_pready                  = st_q.pready;
	assign o_pslverr                 = st_q.pslverr;
	assign o_irq_out_a_extclk_out    = st_q.irq;
	assign o_irq_out_a_extclk_oe     = st_q.pin_a_oe;
	assign o_irq_out_b_trigger_out   = st_q.irq;
	assign o_irq_out_b_trigger_oe    = st_q.pin_b_oe;
	assign o_sample                  = st_q.smp;
	assign o_sample_valid            = st_q.smp_valid;
	assign o_irq                     = st_q.irq;
	assign o_awake                   = st_q.awake;
	assign o_mode                    = st_q.mode;
	assign o_range                   = st_q.ctrl.range;
	assign o_odr_sel                 = st_q.ctrl.odr;
	assign o_filter_pole_half_select = st_q.ctrl.filter_pole_half_select;

	// checks on the block's own behaviour
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_wake_hit;
		(st_q.mode == AMSC_MODE_WAKE) && cap_evt && over;
	endsequence

	sequence s_auto_on;
		st_q.ctrl.auto_meas && !(st_q.ctrl.req_mode == AMSC_MODE_STBY);
	endsequence

	AST_STBY_NO_NEW_FLAG: assert property (
		(st_q.mode == AMSC_MODE_STBY) && !odr_tick |=> ((st_q.status & ~$past(st_q.status)) == 2'b00))
		else $error("new flag raised in standby");

	AST_STBY_NO_SAMPLE: assert property (
		(st_q.mode == AMSC_MODE_STBY) |=> !o_sample_valid)
		else $error("sample produced in standby");

	AST_CLIP_FULL_SCALE: assert property (
		cap_evt && (scaled.y > CLIP_CODE) |=> o_sample_valid && (o_sample.y == 12'h0FFF))
		else $error("y sample not clipped at full scale");

	AST_SCALE_BY_RANGE: assert property (
		cap_evt && (st_q.ctrl.range == 2'b01) && (i_raw.x < 16'h1FFE)
		|=> (o_sample.x == $past(i_raw.x[12:1])))
		else $error("x sample not scaled for range");

	AST_MODE_ON_BOUNDARY: assert property (
		(o_mode != $past(o_mode)) |-> $past(odr_tick) || $past(act_evt))
		else $error("mode changed off a sample boundary");

	AST_WAKE_ONE_SAMPLE: assert property (
		s_wake_hit |=> st_q.status[STAT_ACT])
		else $error("wake-up activity needed more than one sample");

	AST_WAKE_AUTO_MEAS: assert property (
		s_wake_hit ##0 s_auto_on |=> (o_mode == AMSC_MODE_MEAS) [*2])
		else $error("no autonomous switch to measurement");

	AST_IRQ_LEVEL: assert property (
		|(st_q.status & st_q.int_en) |-> o_irq && o_irq_out_a_extclk_out)
		else $error("interrupt level not driven");

	AST_PIN_B_INPUT: assert property (
		$past(st_q.ctrl.ext_trig_en) && st_q.ctrl.ext_trig_en |-> !o_irq_out_b_trigger_oe)
		else $error("pin b driven while used as trigger input");

	AST_WAKE_RATE: assert property (
		(st_q.mode == AMSC_MODE_WAKE) && !st_q.ctrl.ext_clk_en && cap_evt
		|=> !wake_tick [*8])
		else $error("wake-up samples too close together");

	sequence s_trig_hit;
		(st_q.mode == AMSC_MODE_MEAS) && st_q.ctrl.ext_trig_en && edge_b;
	endsequence

	// external clock mode: no pin a edge means no rate step
	AST_PIN_A_CLOCK: assert property (
		st_q.ctrl.ext_clk_en && !edge_a |=> !odr_tick && !wake_tick)
		else $error("rate tick without an external clock edge");

	// a trigger edge in measurement gives a sample next cycle
	AST_TRIG_SAMPLE: assert property (
		s_trig_hit |=> o_sample_valid)
		else $error("trigger edge gave no sample");

	// without trigger, each rate tick in measurement gives a sample
	AST_MEAS_SAMPLE: assert property (
		(st_q.mode == AMSC_MODE_MEAS) && !st_q.ctrl.ext_trig_en && odr_tick
		|=> o_sample_valid)
		else $error("rate tick gave no sample in measurement");

	// wake-up decides on one sample whatever the activity time says
	AST_WAKE_NO_TIMER: assert property (
		s_wake_hit |-> act_evt)
		else $error("wake-up activity waited for the timer");

	// wake-up motion sets the awake output when enabled
	AST_WAKE_AWAKE: assert property (
		s_wake_hit ##0 st_q.ctrl.awake_en |=> o_awake)
		else $error("awake output not set on wake-up motion");

	// standby: the interrupt line can only rise through an enable write
	AST_STBY_NO_IRQ_RISE: assert property (
		(st_q.mode == AMSC_MODE_STBY) && !apb_wr |=> !$rose(o_irq))
		else $error("interrupt raised in standby");

endmodule

// ---- amsc_pin_model.sv ----
// host-side model of the two dual-use pins: external clock and trigger.
// assumes the device's pin outputs and enables come straight from the top.
`timescale 1ns/1ps
module amsc_pin_model (
	// requests from the bench
	input  wire logic i_clk_run,
	input  wire logic i_trig,
	// device side of the pins
	input  wire logic i_a_out,
	input  wire logic i_a_oe,
	input  wire logic i_b_out,
	input  wire logic i_b_oe,
	// resolved pin levels
	output logic      o_pin_a,
	output logic      o_pin_b
);
	logic ext_clk = 1'b0;

	// 160 ns clock, phase unrelated to sys clock; stands low when not running
	initial begin
		#7;
		forever begin
			#80;
			ext_clk = i_clk_run ? ~ext_clk : 1'b0;
		end
	end

	// the host yields whenever the device drives
	assign o_pin_a = i_a_oe ? i_a_out : ext_clk;
	assign o_pin_b = i_b_oe ? i_b_out : i_trig;
endmodule

// ---- test_accel_mode_and_sample_control.sv ----
// self-checking bench: apb tasks drive modes, ranges, rates and irq.
// assumes short divider parameters: 8 cycles per 400 Hz sample, 40 per wake.
`timescale 1ns/1ps
module test_accel_mode_and_sample_control
	import amsc_pkg::*;
;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        run_clk = 0, trig = 0, err, pready, pslverr, smp_v, irq, awake, pole;
	logic        a_out, a_oe, b_out, b_oe, pin_a, pin_b;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic [1:0]  range;
	logic [2:0]  odr;
	amsc_raw_t   raw = '{16'h0010, 16'h0010, 16'h0010};
	amsc_smp_t   smp;
	amsc_mode_t  mode;
	int          bad_count = 0, check_count = 0, cyc = 0, nval = 0, t_last = 0, t_prev = 0, t0;

	always #10 clk = ~clk;

	amsc_top #(.ODR_MAX_DIV_P(8), .WAKE_DIV_P(40), .EXT_ODR_DIV_P(2), .EXT_WAKE_DIV_P(10)) DUT (
		.i_sys_clk(clk), .i_rstn(rstn), .i_paddr(paddr), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_raw(raw),
		.i_irq_out_a_extclk_in(pin_a), .o_irq_out_a_extclk_out(a_out),
		.o_irq_out_a_extclk_oe(a_oe), .i_irq_out_b_trigger_in(pin_b),
		.o_irq_out_b_trigger_out(b_out), .o_irq_out_b_trigger_oe(b_oe),
		.o_sample(smp), .o_sample_valid(smp_v), .o_irq(irq), .o_awake(awake), .o_mode(mode),
		.o_range(range), .o_odr_sel(odr), .o_filter_pole_half_select(pole));

	amsc_pin_model u_pins (.i_clk_run(run_clk), .i_trig(trig), .i_a_out(a_out), .i_a_oe(a_oe),
		.i_b_out(b_out), .i_b_oe(b_oe), .o_pin_a(pin_a), .o_pin_b(pin_b));

	// sample monitor and hang guard; cycle stamps of the last two samples
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (smp_v === 1'b1) begin
			nval <= nval + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
		if (cyc == 30000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; // select held through the transfer
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// no wait-state limit here; the cycle guard ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
		chk(err, 0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		chk(rd, e);
		chk(err, 0);
	endtask

	task automatic wait_smp(input int n);
		int k0, i;
		k0 = nval;
		i = 0;
		while (nval < k0 + n && i < 2000) begin
			@(posedge clk);
			i++;
		end
		chk(i < 2000, 1);
	endtask

	task automatic wait_mode(input amsc_mode_t m);
		int i;
		i = 0;
		while (mode !== m && i < 400) begin
			@(posedge clk);
			i++;
		end
		chk(mode, m);
	endtask

	// shift by range, then clip at full scale
	function automatic logic [31:0] clip(input logic [15:0] v, input int r);
		logic [15:0] s;
		s = v >> ((r == 3) ? 2 : r);
		return (s > 16'h0FFF) ? 32'h0000_0FFF : {20'h0_0000, s[11:0]};
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		chk(mode, AMSC_MODE_STBY);
		chk(pole, 0);
		rdchk(OFS_CTRL, 32'h0000_0030);
		rdchk(OFS_ACT, 32'h0001_0100);
		rdchk(OFS_STATUS, 32'h0000_0000);
		t0 = nval;
		repeat (50) @(posedge clk);
		chk(nval - t0, 0);
		apb(8'h20, 1'b0, 32'h0000_0000);
		chk(err, 1);
		chk(rd, 32'h0000_0000);
		// every range, with one axis past full scale in ranges 0 and 1
		raw <= '{16'h0123, 16'h2000, 16'h0FFF};
		for (int r = 0; r < 4; r++) begin
			wr(OFS_CTRL, 32'h0000_0052 | (r << 2));
			wait_smp(2);
			chk(mode, AMSC_MODE_MEAS);
			chk(smp.x, clip(16'h0123, r));
			chk(smp.y, clip(16'h2000, r));
			chk(smp.z, clip(16'h0FFF, r));
		end
		// every rate code; codes past 5 act as 400 Hz
		for (int o = 0; o < 8; o++) begin
			wr(OFS_CTRL, 32'h0000_0002 | (o << 4));
			wait_smp(3);
			chk(t_last - t_prev, (o > 5) ? 8 : (8 << (5 - o)));
			chk(odr, o);
		end
		wr(OFS_CTRL, 32'h0000_00D2);
		repeat (2) @(posedge clk);
		chk(pole, 1);
		// pending flags survive standby, nothing new is raised
		wr(OFS_INT_EN, 32'h0000_0001);
		wait_smp(1);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		wr(OFS_CTRL, 32'h0000_0050);
		wait_mode(AMSC_MODE_STBY);
		@(posedge clk); // the boundary tick's own sample is still counted
		t0 = nval;
		repeat (40) @(posedge clk);
		chk(nval - t0, 0);
		chk(irq, 1);
		rdchk(OFS_STATUS, 32'h0000_0003);
		wr(OFS_INT_EN, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		wr(OFS_INT_EN, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		wr(OFS_INT_CLR, 32'h0000_0003);
		repeat (40) @(posedge clk);
		chk({irq, a_out, b_out}, 0);
		rdchk(OFS_STATUS, 32'h0000_0000);
		// wake-up: slow sampling, then motion switches to measurement
		raw <= '{16'h0010, 16'h0010, 16'h0010};
		wr(OFS_INT_EN, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_0C53);
		wait_mode(AMSC_MODE_WAKE);
		rdchk(OFS_ACT, 32'h0001_0100);
		wait_smp(3);
		chk(t_last - t_prev, 40);
		chk(awake, 0);
		raw <= '{16'h0200, 16'h0010, 16'h0010};
		wait_mode(AMSC_MODE_MEAS);
		repeat (2) @(posedge clk);
		chk({awake, irq}, 2'b11);
		rdchk(OFS_CTRL, 32'h0000_0C52);
		raw <= '{16'h0010, 16'h0010, 16'h0010};
		wr(OFS_INT_CLR, 32'h0000_0003);
		// external trigger on pin b at the slowest rate
		wr(OFS_CTRL, 32'h0000_0202);
		repeat (4) @(posedge clk);
		chk(b_oe, 0);
		trig <= 1;
		wait_smp(1);
		trig <= 0;
		repeat (8) @(posedge clk);
		trig <= 1;
		t0 = cyc;
		wait_smp(1);
		chk(t_last - t0 < 8, 1);
		trig <= 0;
		// external clock on pin a: two edges per sample at code 5
		wr(OFS_CTRL, 32'h0000_0152);
		run_clk <= 1;
		repeat (4) @(posedge clk);
		chk(a_oe, 0);
		wait_smp(3);
		chk(t_last - t_prev, 16);
		// with the clock stopped no sample boundary, so no mode change
		run_clk <= 0;
		wr(OFS_CTRL, 32'h0000_0150);
		repeat (40) @(posedge clk);
		chk(mode, AMSC_MODE_MEAS);
		run_clk <= 1;
		wait_mode(AMSC_MODE_STBY);
		finish_test();
	end
endmodule
